// File: hw/perf_pkg.sv
package perf_pkg;

  // Structure sizes
  localparam int NUM_CH    = 8;
  localparam int ADDR_W    = 32;
  localparam int DATA_W    = 32;
  localparam int TIME_W    = 24;
  localparam int PADDR_W   = 12;
  localparam int CH_IDX_W  = 3;
  localparam int MODE_W    = 3;
  localparam int SEL_W     = 2;
  localparam int TICK_CNT_W = 16;

  // Measurement modes held in a channel's configuration word
  localparam logic [MODE_W-1:0] MODE_OFF         = 3'h0;
  localparam logic [MODE_W-1:0] MODE_IN_RANGE    = 3'h1;
  localparam logic [MODE_W-1:0] MODE_START_END   = 3'h2;
  localparam logic [MODE_W-1:0] MODE_RANGE_RANGE = 3'h3;
  localparam logic [MODE_W-1:0] MODE_ACCESS      = 3'h4;
  localparam logic [MODE_W-1:0] MODE_CALL        = 3'h5;

  // Sampling interval selection
  localparam logic [SEL_W-1:0] SEL_FAST = 2'h0;
  localparam logic [SEL_W-1:0] SEL_MID  = 2'h1;
  localparam logic [SEL_W-1:0] SEL_SLOW = 2'h2;

  // Sampling intervals in nanoseconds and the cycle counts derived from them
  localparam int CLK_PERIOD_NS      = 4;
  localparam int SAMPLE_FAST_NS     = 20;
  localparam int SAMPLE_MID_NS      = 1600;
  localparam int SAMPLE_SLOW_NS     = 52000;
  localparam int SAMPLE_FAST_CYCLES = (SAMPLE_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_MID_CYCLES  = (SAMPLE_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_SLOW_CYCLES = (SAMPLE_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Global register byte offsets
  localparam logic [PADDR_W-1:0] OFS_CTRL    = 12'h000;
  localparam logic [PADDR_W-1:0] OFS_CLEAR   = 12'h004;
  localparam logic [PADDR_W-1:0] OFS_TIMEOUT = 12'h008;
  localparam logic [PADDR_W-1:0] OFS_MAXPASS = 12'h00c;
  localparam logic [PADDR_W-1:0] OFS_STATUS  = 12'h010;

  // Channel window: region 0x100, 0x20 bytes per channel
  localparam logic [3:0] CH_REGION = 4'h1;
  localparam logic [4:0] CH_CFG    = 5'h00;
  localparam logic [4:0] CH_START  = 5'h04;
  localparam logic [4:0] CH_END    = 5'h08;
  localparam logic [4:0] CH_TIME   = 5'h0c;
  localparam logic [4:0] CH_PASS   = 5'h10;
  localparam logic [4:0] CH_MAX    = 5'h14;
  localparam logic [4:0] CH_MIN    = 5'h18;

  // Field positions
  localparam int CLEAR_ONE_BIT    = 8;
  localparam int CLEAR_ALL_BIT    = 9;
  localparam int STAT_TIMEOUT_BIT = 8;
  localparam int STAT_PASSLIM_BIT = 9;

  // Reset and limit values
  localparam logic [TIME_W-1:0] TIME_ZERO = 24'h000000;
  localparam logic [TIME_W-1:0] TIME_FULL = 24'hffffff;
  localparam logic [TIME_W-1:0] TIME_ONE  = 24'h000001;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h00000000;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

  // Observed target bus cycle
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              valid;
    logic              prefetch;
    logic              cpu_master;
  } bus_obs_t;

  // Channel configuration: mode and an address pair
  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic [ADDR_W-1:0] lo;
    logic [ADDR_W-1:0] hi;
  } chan_cfg_t;

  // Channel results
  typedef struct packed {
    logic [TIME_W-1:0] elapsed;
    logic [TIME_W-1:0] passes;
    logic [TIME_W-1:0] max_t;
    logic [TIME_W-1:0] min_t;
    logic              active;
  } chan_stat_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } meas_state_t;

endpackage : perf_pkg

// File: hw/sample_tick.sv
`timescale 1ns/1ns
`default_nettype none
module sample_tick #(
  parameter int SLOW_CYCLES = perf_pkg::SAMPLE_SLOW_CYCLES
) (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // Interval choice and tick
  input  wire logic [perf_pkg::SEL_W-1:0] sel,
  output var  logic                      tick
);
  import perf_pkg::*;

  logic [TICK_CNT_W-1:0] count;
  logic [TICK_CNT_W-1:0] limit;

  // Terminal count for the chosen interval
  always_comb begin
    unique case (sel)
      SEL_FAST: limit = TICK_CNT_W'(SAMPLE_FAST_CYCLES - 1);
      SEL_MID:  limit = TICK_CNT_W'(SAMPLE_MID_CYCLES - 1);
      default:  limit = TICK_CNT_W'(SLOW_CYCLES - 1);
    endcase
  end

  // Free-running divider; >= so a shorter interval chosen mid-count wraps at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (count >= limit) begin
      count <= '0;
      tick  <= 1'b1;
    end else begin
      count <= count + TICK_CNT_W'(1);
      tick  <= 1'b0;
    end
  end

endmodule : sample_tick
`default_nettype wire

// File: hw/perf_channel.sv
`timescale 1ns/1ns
`default_nettype none
module perf_channel (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Observed bus and emulation state
  input  wire perf_pkg::bus_obs_t    obs,
  input  wire logic                  emu_break,
  input  wire logic                  tick,
  input  wire logic                  clear,
  // Own and partner configuration
  input  wire perf_pkg::chan_cfg_t   cfg,
  input  wire perf_pkg::chan_cfg_t   partner,
  // Results
  output var  perf_pkg::chan_stat_t  stat
);
  import perf_pkg::*;

  meas_state_t       state;
  meas_state_t       next_state;
  logic [TIME_W-1:0] seg;
  logic [TIME_W-1:0] seg_end;
  logic              prev_in_own;
  logic              fetch;
  logic              in_own;
  logic              in_part;
  logic              at_lo;
  logic              at_hi;
  logic              pass_inc;
  logic              seg_done;
  logic              seg_start;

  // Prefetch cycles drive the state changes; data cycles only feed access counting
  assign fetch   = obs.valid & obs.prefetch;
  assign in_own  = (obs.addr >= cfg.lo) && (obs.addr <= cfg.hi);
  assign in_part = (obs.addr >= partner.lo) && (obs.addr <= partner.hi);
  assign at_lo   = obs.addr == cfg.lo;
  assign at_hi   = obs.addr == cfg.hi;

  // Per-mode start, stop and count decisions
  always_comb begin
    next_state = state;
    pass_inc   = 1'b0;
    seg_done   = 1'b0;
    seg_start  = 1'b0;
    unique case (cfg.mode)
      MODE_IN_RANGE, MODE_ACCESS, MODE_CALL: begin
        if (fetch) begin
          next_state = in_own ? ST_RUN : ST_IDLE;
        end
        if (cfg.mode == MODE_IN_RANGE) begin
          pass_inc = fetch & at_hi;
        end else if (cfg.mode == MODE_ACCESS) begin
          // Data accesses by the processor only, while the subroutine runs
          pass_inc = obs.valid & ~obs.prefetch & obs.cpu_master & in_part & (state == ST_RUN);
        end else begin
          pass_inc = fetch & (obs.addr == partner.lo) & prev_in_own;
        end
      end
      MODE_START_END: begin
        if (state == ST_IDLE) begin
          if (fetch & at_lo) begin
            next_state = ST_RUN;
            seg_start  = 1'b1;
          end
        end else if (fetch & at_hi) begin
          next_state = ST_IDLE;
          pass_inc   = 1'b1;
          seg_done   = 1'b1;
        end else if (emu_break) begin
          next_state = ST_IDLE;
        end
      end
      MODE_RANGE_RANGE: begin
        if (state == ST_IDLE) begin
          if (fetch & in_own) begin
            next_state = ST_RUN;
          end
        end else if (fetch & in_part) begin
          next_state = ST_IDLE;
          pass_inc   = 1'b1;
        end else if (emu_break) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // Measurement state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_IDLE;
      prev_in_own <= 1'b0;
    end else if (clear) begin
      state       <= ST_IDLE;
      prev_in_own <= 1'b0;
    end else begin
      state <= next_state;
      if (fetch) begin
        prev_in_own <= in_own;
      end
    end
  end

  // Elapsed time; saturates rather than wrapping so an overrun stays visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat.elapsed <= TIME_ZERO;
    end else if (clear) begin
      stat.elapsed <= TIME_ZERO;
    end else if ((state == ST_RUN) && tick && (stat.elapsed != TIME_FULL)) begin
      stat.elapsed <= stat.elapsed + TIME_ONE;
    end
  end

  // Single-pass time for the extremes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seg <= TIME_ZERO;
    end else if (clear || seg_start) begin
      seg <= TIME_ZERO;
    end else if ((state == ST_RUN) && tick && (seg != TIME_FULL)) begin
      seg <= seg + TIME_ONE;
    end
  end

  // Pass time with the closing edge's tick, which elapsed counts as well
  assign seg_end = (tick && (seg != TIME_FULL)) ? seg + TIME_ONE : seg;

  // Maximum and minimum pass time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat.max_t <= TIME_ZERO;
      stat.min_t <= TIME_FULL;
    end else if (clear) begin
      stat.max_t <= TIME_ZERO;
      stat.min_t <= TIME_FULL;
    end else if (seg_done) begin
      if (seg_end > stat.max_t) begin
        stat.max_t <= seg_end;
      end
      if (seg_end < stat.min_t) begin
        stat.min_t <= seg_end;
      end
    end
  end

  // Pass or event counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat.passes <= TIME_ZERO;
    end else if (clear) begin
      stat.passes <= TIME_ZERO;
    end else if (pass_inc && (stat.passes != TIME_FULL)) begin
      stat.passes <= stat.passes + TIME_ONE;
    end
  end

  // Activity flag mirrors the state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat.active <= 1'b0;
    end else begin
      stat.active <= (next_state == ST_RUN) && !clear;
    end
  end

endmodule : perf_channel
`default_nettype wire

// File: hw/perf_analyzer.sv
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module perf_analyzer #(
  parameter int SLOW_CYCLES = perf_pkg::SAMPLE_SLOW_CYCLES
) (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [perf_pkg::PADDR_W-1:0]  paddr,
  input  wire logic [perf_pkg::DATA_W-1:0]   pwdata,
  output var  logic [perf_pkg::DATA_W-1:0]   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  // Observed target bus and emulator state
  input  wire perf_pkg::bus_obs_t            obs,
  input  wire logic                          emu_break,
  // Break request to the emulator
  output var  logic                          timeout_break
);
  import perf_pkg::*;

  chan_cfg_t             cfg [NUM_CH];
  chan_stat_t            stat [NUM_CH];
  logic [NUM_CH-1:0]     clear_ch;
  logic [NUM_CH-1:0]     next_clear;
  logic [SEL_W-1:0]      sample_sel;
  logic [TIME_W-1:0]     timeout_val;
  logic [TIME_W-1:0]     max_pass;
  logic                  timeout_hit;
  logic                  passlim_hit;
  logic                  tick;
  logic                  access;
  logic                  wr_en;
  logic                  in_ch_region;
  logic [CH_IDX_W-1:0]   ch_sel;
  logic [4:0]            ch_reg;
  logic [DATA_W-1:0]     rd_data;
  logic                  rd_ok;
  logic [MODE_W-1:0]     wr_mode;
  logic                  wr_pair_mode;
  logic [NUM_CH-1:0]     active_vec;

  // Address split into global and per-channel windows
  assign in_ch_region = paddr[PADDR_W-1:8] == CH_REGION;
  assign ch_sel       = paddr[7:5];
  assign ch_reg       = paddr[4:0];

  // A write lands only on the edge where the access phase completes
  assign access = psel & penable;
  assign wr_en  = access & pready & pwrite;

  // Pair modes need the following channel, so they are refused on odd channels
  assign wr_mode      = pwdata[MODE_W-1:0];
  assign wr_pair_mode = (wr_mode == MODE_RANGE_RANGE) || (wr_mode == MODE_ACCESS) || (wr_mode == MODE_CALL);

  // Sampling interval generator
  sample_tick #(
    .SLOW_CYCLES (SLOW_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .sel     (sample_sel),
    .tick    (tick)
  );

  // Eight channels; each one sees the neighbour of its pair as partner
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    perf_channel u_ch (
      .pclk      (pclk),
      .presetn   (presetn),
      .obs       (obs),
      .emu_break (emu_break),
      .tick      (tick),
      .clear     (clear_ch[i]),
      .cfg       (cfg[i]),
      .partner   (cfg[i ^ 1]),
      .stat      (stat[i])
    );
    assign active_vec[i] = stat[i].active;
  end

  // Clear request decode from the clear register
  always_comb begin
    next_clear = '0;
    if (wr_en && !in_ch_region && (paddr == OFS_CLEAR)) begin
      if (pwdata[CLEAR_ALL_BIT]) begin
        next_clear = '1;
      end else if (pwdata[CLEAR_ONE_BIT]) begin
        next_clear[pwdata[CH_IDX_W-1:0]] = 1'b1;
      end
    end
  end

  // Clear pulses to the channel counters, one cycle after the write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_ch <= '0;
    end else begin
      clear_ch <= next_clear;
    end
  end

  // Global control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_sel  <= SEL_FAST;
      timeout_val <= TIME_ZERO;
      max_pass    <= TIME_ZERO;
    end else if (wr_en && !in_ch_region) begin
      if (paddr == OFS_CTRL) begin
        sample_sel <= pwdata[SEL_W-1:0];
      end
      if (paddr == OFS_TIMEOUT) begin
        timeout_val <= pwdata[TIME_W-1:0];
      end
      if (paddr == OFS_MAXPASS) begin
        max_pass <= pwdata[TIME_W-1:0];
      end
    end
  end

  // Channel configuration; clearing a channel also drops its settings
  for (genvar i = 0; i < NUM_CH; i++) begin : g_cfg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg[i].mode <= MODE_OFF;
        cfg[i].lo   <= ADDR_ZERO;
        cfg[i].hi   <= ADDR_ZERO;
      end else if (next_clear[i]) begin
        cfg[i].mode <= MODE_OFF;
        cfg[i].lo   <= ADDR_ZERO;
        cfg[i].hi   <= ADDR_ZERO;
      end else if (wr_en && in_ch_region && (ch_sel == CH_IDX_W'(i))) begin
        if (ch_reg == CH_CFG) begin
          if (wr_pair_mode && ((i % 2) == 1)) begin
            cfg[i].mode <= MODE_OFF;
          end else if (wr_mode > MODE_CALL) begin
            cfg[i].mode <= MODE_OFF;
          end else begin
            cfg[i].mode <= wr_mode;
          end
        end
        if (ch_reg == CH_START) begin
          cfg[i].lo <= pwdata;
        end
        if (ch_reg == CH_END) begin
          cfg[i].hi <= pwdata;
        end
      end
    end
  end

  // Channel one limits; zero disables each check
  assign timeout_hit = (timeout_val != TIME_ZERO) && (stat[0].elapsed > timeout_val);
  assign passlim_hit = (max_pass != TIME_ZERO) && (stat[0].passes >= max_pass);

  // Break request is sticky; a new hit wins over a clear of channel one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_break <= 1'b0;
    end else if (timeout_hit || passlim_hit) begin
      timeout_break <= 1'b1;
    end else if (clear_ch[0]) begin
      timeout_break <= 1'b0;
    end
  end

  // Read mux; unmapped addresses answer with an error and zero data
  always_comb begin
    rd_data = DATA_ZERO;
    rd_ok   = 1'b1;
    if (in_ch_region) begin
      unique case (ch_reg)
        CH_CFG:   rd_data = DATA_W'(cfg[ch_sel].mode);
        CH_START: rd_data = cfg[ch_sel].lo;
        CH_END:   rd_data = cfg[ch_sel].hi;
        CH_TIME:  rd_data = DATA_W'(stat[ch_sel].elapsed);
        CH_PASS:  rd_data = DATA_W'(stat[ch_sel].passes);
        CH_MAX:   rd_data = DATA_W'(stat[ch_sel].max_t);
        CH_MIN:   rd_data = DATA_W'(stat[ch_sel].min_t);
        default:  rd_ok   = 1'b0;
      endcase
    end else begin
      unique case (paddr)
        OFS_CTRL:    rd_data = DATA_W'(sample_sel);
        OFS_CLEAR:   rd_data = DATA_ZERO;
        OFS_TIMEOUT: rd_data = DATA_W'(timeout_val);
        OFS_MAXPASS: rd_data = DATA_W'(max_pass);
        OFS_STATUS: begin
          rd_data                   = DATA_W'(active_vec);
          rd_data[STAT_TIMEOUT_BIT] = timeout_break;
          rd_data[STAT_PASSLIM_BIT] = passlim_hit;
        end
        default:     rd_ok = 1'b0;
      endcase
    end
  end

  // One wait state: answer registered in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= DATA_ZERO;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? DATA_ZERO : rd_data;
      pslverr <= !rd_ok;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : perf_analyzer
`default_nettype wire

// File: sim/perf_analyzer_chk.sv
`timescale 1ns/1ns
`default_nettype none
module perf_analyzer_chk #(
  parameter int SLOW_CYCLES = 20
) (
  // Clock and reset
  input wire logic                         pclk,
  input wire logic                         presetn,
  // APB side
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [perf_pkg::PADDR_W-1:0] paddr,
  input wire logic [perf_pkg::DATA_W-1:0]  pwdata,
  input wire logic [perf_pkg::DATA_W-1:0]  prdata,
  input wire logic                         pready,
  input wire logic                         pslverr,
  // Break request
  input wire logic                         timeout_break
);
  import perf_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed write to the clear register that reaches channel 0
  logic clr0;
  assign clr0 = psel && penable && pready && pwrite && paddr == OFS_CLEAR
                && (pwdata[CLEAR_ALL_BIT] || (pwdata[CLEAR_ONE_BIT] && pwdata[2:0] == 3'h0));
  // Aligned offsets that decode to a register
  function automatic logic mapped(input logic [PADDR_W-1:0] a);
    return a inside {OFS_CTRL, OFS_CLEAR, OFS_TIMEOUT, OFS_MAXPASS, OFS_STATUS}
           || (a[11:8] == CH_REGION && a[4:0] <= CH_MIN);
  endfunction : mapped
  // One wait state, then a single-cycle answer
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_done; pready ##1 !pready; endsequence
  a_one_wait: assert property (s_wait |=> s_done)
    else $error("answer not one cycle after access");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  a_ready_cause: assert property (!(psel && penable) |=> !pready)
    else $error("ready without access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_decode: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == !mapped(paddr))
    else $error("error flag does not match decode");
  a_write_rdata: assert property (pready && pwrite |-> prdata == DATA_ZERO)
    else $error("read data not zero on write");
  a_clear_reads_zero: assert property (pready && !pwrite && paddr == OFS_CLEAR |-> prdata == DATA_ZERO)
    else $error("clear register reads nonzero");
  a_break_sticky: assert property (timeout_break && !clr0 && !$past(clr0) |=> timeout_break)
    else $error("break dropped without a clear");
endmodule : perf_analyzer_chk
bind perf_analyzer perf_analyzer_chk #(.SLOW_CYCLES(SLOW_CYCLES)) perf_analyzer_chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timeout_break(timeout_break));
`default_nettype wire

// File: sim/target_bus.sv
`timescale 1ns/1ns
`default_nettype none
module target_bus (
  // Clock
  input  wire logic               pclk,
  // Observed bus cycle
  output var  perf_pkg::bus_obs_t obs
);
  import perf_pkg::*;
  initial obs = '0;
  // Straight-line fetch streams, so no start or end lands in a branch shadow
  // Idle cycles show the inverted address so a stale value never looks live
  task automatic cyc(input logic [31:0] a, input logic pf, input logic cpu, input int n);
    repeat (n) begin
      @(posedge pclk);
      obs <= '{addr: a, valid: 1'b1, prefetch: pf, cpu_master: cpu};
    end
    @(posedge pclk);
    obs <= '{addr: ~a, valid: 1'b0, prefetch: 1'b0, cpu_master: 1'b0};
  endtask : cyc
endmodule : target_bus
`default_nettype wire

// File: sim/perf_analyzer_bench.sv
`timescale 1ns/1ns
`default_nettype none
module perf_analyzer_bench;
  import perf_pkg::*;
  localparam int SLOW = 20;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, emu_break, timeout_break, err;
  logic [PADDR_W-1:0] paddr;
  logic [DATA_W-1:0]  pwdata, prdata, rd, a, e;
  bus_obs_t           obs;
  int                 n_errors, n_tests, cyc_cnt, seed, p, mx, mn;
  int                 m_time[8], m_pass[8];
  int                 lens[2] = '{15, 25};

  perf_analyzer #(.SLOW_CYCLES(SLOW)) perf_analyzer_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .obs(obs),
    .emu_break(emu_break), .timeout_break(timeout_break));
  target_bus target_bus_i (.pclk(pclk), .obs(obs));

  // Free-running clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic test_done;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // Hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge pclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // APB transfer: request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the hang guard ends a wait that never sees ready
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] ad, input logic [31:0] d); apb(1'b1, ad, d); endtask : wr
  task automatic rchk(input string what, input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    check(what, rd, exp);
  endtask : rchk
  function automatic logic [11:0] ca(input int n, input logic [4:0] off);
    return 12'h100 + 12'(n * 32) + {7'h0, off};
  endfunction : ca
  task automatic cfg(input int n, input logic [2:0] m, input logic [31:0] lo, input logic [31:0] hi);
    wr(ca(n, CH_START), lo);
    wr(ca(n, CH_END), hi);
    wr(ca(n, CH_CFG), {29'h0, m});
  endtask : cfg
  task automatic res(input int n);
    rchk("elapsed", ca(n, CH_TIME), m_time[n]);
    rchk("passes", ca(n, CH_PASS), m_pass[n]);
  endtask : res
  task automatic clr_all;
    wr(OFS_CLEAR, 32'h00000200);
    foreach (m_time[i]) begin m_time[i] = 0; m_pass[i] = 0; end
  endtask : clr_all

  initial begin
    seed = 32'he6c8;
    {psel, penable, pwrite, emu_break, presetn} = 5'h00;
    paddr = 12'h000; pwdata = 32'h0; n_errors = 0; n_tests = 0; cyc_cnt = 0;
    foreach (m_time[i]) begin m_time[i] = 0; m_pass[i] = 0; end
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset state and an unmapped offset
    rchk("ctrl", OFS_CTRL, 32'h0);
    rchk("min", ca(0, CH_MIN), 32'h00ffffff);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    $display("test reset done");
    // Modes 1 to 5 and invalid 6 on every channel; pair modes only on even-numbered channels
    for (int n = 0; n < 8; n++) begin
      for (int m = 6; m >= 1; m--) begin
        wr(ca(n, CH_CFG), m);
        e = (m > 5 || (m >= 3 && n % 2 == 1)) ? 0 : m;
        rchk("mode", ca(n, CH_CFG), e);
      end
    end
    clr_all();
    for (int n = 0; n < 8; n++) rchk("cfg cleared", ca(n, CH_CFG), 32'h0);
    $display("test modes done");
    // In-range timing: windows of 20 and 10 cycles, data cycles never count as fetches
    cfg(0, MODE_IN_RANGE, 32'h1000, 32'h1fff);
    a = 32'h1000 + ($random(seed) & 32'h7fe);
    target_bus_i.cyc(a, 1, 1, 17);
    target_bus_i.cyc(32'h1fff, 1, 1, 1);
    target_bus_i.cyc(32'h3000 + ($random(seed) & 32'hfff), 1, 1, 8);
    target_bus_i.cyc(32'h1500, 0, 1, 3);
    target_bus_i.cyc(a, 1, 1, 7);
    target_bus_i.cyc(32'h1fff, 1, 1, 1);
    target_bus_i.cyc(32'h3000, 1, 1, 1);
    m_time[0] += 30 / SAMPLE_FAST_CYCLES;
    m_pass[0] += 2;
    res(0);
    $display("test in_range done");
    // Start-to-end timing: two passes, then one cut short by a break
    cfg(2, MODE_START_END, 32'h1000, 32'h1fff);
    mx = 0; mn = 32'hffffff;
    foreach (lens[i]) begin
      target_bus_i.cyc(32'h1000, 1, 1, 1);
      target_bus_i.cyc(32'h3000, 1, 1, lens[i] - 3);
      target_bus_i.cyc(32'h1fff, 1, 1, 1);
      p = lens[i] / SAMPLE_FAST_CYCLES;
      m_time[2] += p; m_pass[2]++;
      if (p > mx) mx = p;
      if (p < mn) mn = p;
    end
    target_bus_i.cyc(32'h1000, 1, 1, 1);
    target_bus_i.cyc(32'h3000, 1, 1, 7);
    @(posedge pclk) emu_break <= 1'b1;
    @(posedge pclk) emu_break <= 1'b0;
    target_bus_i.cyc(32'h3000, 1, 1, 8);
    m_time[2] += 10 / SAMPLE_FAST_CYCLES;
    res(2);
    rchk("max", ca(2, CH_MAX), mx);
    rchk("min", ca(2, CH_MIN), mn);
    $display("test start_end done");
    // Range-to-range timing over a 20-cycle window
    cfg(4, MODE_RANGE_RANGE, 32'h1000, 32'h13ff);
    cfg(5, MODE_OFF, 32'h1c00, 32'h1fff);
    target_bus_i.cyc(32'h1100, 1, 1, 1);
    target_bus_i.cyc(32'h3000, 1, 1, 17);
    target_bus_i.cyc(32'h1c10, 1, 1, 1);
    target_bus_i.cyc(32'h3000, 1, 1, 1);
    m_time[4] += 20 / SAMPLE_FAST_CYCLES;
    m_pass[4]++;
    res(4);
    $display("test range_range done");
    // Access counting: only processor data cycles inside the area while in the routine
    cfg(6, MODE_ACCESS, 32'h1000, 32'h1fff);
    cfg(7, MODE_OFF, 32'h8000, 32'h80ff);
    target_bus_i.cyc(32'h1010, 1, 1, 2);
    target_bus_i.cyc(32'h8010, 0, 1, 2);
    target_bus_i.cyc(32'h8020, 0, 0, 3);
    target_bus_i.cyc(32'h9000, 0, 1, 1);
    target_bus_i.cyc(32'h80fc, 0, 1, 1);
    target_bus_i.cyc(32'h3000, 1, 1, 1);
    target_bus_i.cyc(32'h8010, 0, 1, 2);
    rchk("accesses", ca(6, CH_PASS), 32'h3);
    $display("test access done");
    // Call counting: only calls made from inside the caller count
    clr_all();
    cfg(0, MODE_CALL, 32'h1000, 32'h1fff);
    cfg(1, MODE_OFF, 32'h5000, 32'h50ff);
    target_bus_i.cyc(32'h1010, 1, 1, 1);
    target_bus_i.cyc(32'h5000, 1, 1, 1);
    target_bus_i.cyc(32'h3000, 1, 1, 1);
    target_bus_i.cyc(32'h5000, 1, 1, 1);
    rchk("calls", ca(0, CH_PASS), 32'h1);
    $display("test call done");
    // Timeout on channel 0 forces a break, clearing that channel releases it
    wr(OFS_CLEAR, 32'h00000100);
    wr(OFS_TIMEOUT, 32'h3);
    cfg(0, MODE_IN_RANGE, 32'h1000, 32'h1fff);
    target_bus_i.cyc(32'h1010, 1, 1, 24);
    target_bus_i.cyc(32'h3000, 1, 1, 1);
    check("break", {31'h0, timeout_break}, 32'h1);
    rchk("status", OFS_STATUS, 32'h100);
    wr(OFS_TIMEOUT, 32'h0);
    wr(OFS_CLEAR, 32'h00000100);
    repeat (3) @(posedge pclk);
    check("break cleared", {31'h0, timeout_break}, 32'h0);
    rchk("cleared time", ca(0, CH_TIME), 32'h0);
    $display("test timeout done");
    // Mid, slow and unassigned select 3: a window of two periods gives two ticks
    cfg(3, MODE_IN_RANGE, 32'h1000, 32'h1fff);
    for (int s = 1; s <= 3; s++) begin
      wr(OFS_CTRL, s);
      p = (s == 1) ? SAMPLE_MID_CYCLES : SLOW;
      target_bus_i.cyc(32'h1010, 1, 1, 2 * p - 1);
      target_bus_i.cyc(32'h3000, 1, 1, 1);
      m_time[3] += 2;
      rchk("interval time", ca(3, CH_TIME), m_time[3]);
    end
    $display("test interval done");
    test_done();
  end
endmodule : perf_analyzer_bench
`default_nettype wire
